// ==== ecs_cfg.svh ====
// Purpose: constants for the externally paced conversion sequencer
// Assumes: 125 MHz clock, 8 ns period
// Notes: timing counts derive from printed times in ns
`ifndef ECS_CFG_SVH
`define ECS_CFG_SVH

`define ECS_CLK_PERIOD_NS 8
`define ECS_PULSE_MIN_NS 100
`define ECS_PULSE_MAX_NS 700
// least time rounds up, longest rounds down
`define ECS_PULSE_MIN_CYC ((`ECS_PULSE_MIN_NS + `ECS_CLK_PERIOD_NS - 1) / `ECS_CLK_PERIOD_NS)
`define ECS_PULSE_MAX_CYC (`ECS_PULSE_MAX_NS / `ECS_CLK_PERIOD_NS)
`define ECS_PARALLEL_STEPS 16
`define ECS_SERIAL_STEPS 17
`define ECS_INT_DIV 8

`endif

// ==== ecs_pkg.sv ====
// Purpose: types for the externally paced conversion sequencer
// Assumes: nothing
// Notes: one-hot state codes
package ecs_pkg;
    typedef enum logic [2:0] {
        ECS_IDLE = 3'b001,
        ECS_CONV = 3'b010,
        ECS_SHIFT = 3'b100
    } ecs_state_type;
endpackage

// ==== ecs_sequencer.sv ====
// Purpose: conversion sequencer paced by active-low trigger pulses
// Assumes: trigger input synchronous to clk_in
// Notes: internal clock used only when trigger idles high
//
// Summary of operation
// - a trigger rising edge suppresses the internal step, one step per pulse
// - parallel result complete and held after the sixteenth pulse
// - serial result fully shifted out after the seventeenth pulse
// - status goes high after the first pulse
// - status returns low after the seventeenth pulse
`timescale 1ns/1ns
`default_nettype none
`include "ecs_cfg.svh"

module ecs_sequencer
    import ecs_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int INT_DIV = `ECS_INT_DIV
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // controller side
    input wire logic start_conv_n_in,
    input wire logic comparator_in,
    // result side
    output logic status_out,
    output logic [WIDTH-1:0] data_out,
    output logic serial_out,
    output logic step_out,
    output logic pulse_err_out
);
    import ecs_pkg::*;

    localparam int PMIN = `ECS_PULSE_MIN_CYC;
    localparam int PMAX = `ECS_PULSE_MAX_CYC;

    // ----------------------------------------
    // trigger pulse watch
    // ----------------------------------------
    logic trig_q, trig_d;
    logic [7:0] low_cnt_q, low_cnt_d;
    logic ext_step;
    logic err_d, err_q;

    always_comb begin
        trig_d = start_conv_n_in;
        low_cnt_d = low_cnt_q;
        err_d = 1'b0;
        if (!start_conv_n_in) begin
            if (low_cnt_q != 8'hff) begin
                low_cnt_d = low_cnt_q + 8'h01;
            end
        end else begin
            low_cnt_d = 8'h00;
        end
        // a pulse outside the window still steps; flag it for the controller
        if (ext_step && ((low_cnt_q < 8'(PMIN)) || (low_cnt_q > 8'(PMAX)))) begin
            err_d = 1'b1;
        end
    end

    // rising edge marks one externally paced step
    assign ext_step = start_conv_n_in && !trig_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            trig_q <= 1'b1;
            low_cnt_q <= 8'h00;
            err_q <= 1'b0;
        end else begin
            trig_q <= trig_d;
            low_cnt_q <= low_cnt_d;
            err_q <= err_d;
        end
    end

    // ----------------------------------------
    // internal clock and step select
    // ----------------------------------------
    logic [7:0] div_q, div_d;
    logic int_tick;
    logic step;

    always_comb begin
        div_d = (div_q == 8'(INT_DIV - 1)) ? 8'h00 : div_q + 8'h01;
        // any trigger activity restarts the divider, so it never races a pulse
        if (!start_conv_n_in || ext_step) begin
            div_d = 8'h00;
        end
    end

    assign int_tick = (div_q == 8'(INT_DIV - 1)) && start_conv_n_in && trig_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_d;
        end
    end

    // ----------------------------------------
    // step sequencer
    // ----------------------------------------
    ecs_state_type st_q, st_d;
    logic [4:0] cnt_q, cnt_d;
    logic [WIDTH-1:0] sar_q, sar_d, data_q, data_d;
    logic status_q, status_d, ser_q, ser_d, step_q;
    logic ext_mode_q, ext_mode_d;

    // in external mode internal ticks are inhibited
    assign step = ext_step || (ext_mode_q ? 1'b0 : (st_q != ECS_IDLE) && int_tick);

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sar_d = sar_q;
        data_d = data_q;
        status_d = status_q;
        ser_d = ser_q;
        ext_mode_d = ext_mode_q;
        case (st_q)
            ECS_IDLE: begin
                if (ext_step) begin
                    // first pulse opens the frame and already resolves the msb
                    st_d = ECS_CONV;
                    cnt_d = 5'd1;
                    status_d = 1'b1;
                    ext_mode_d = 1'b1;
                    ser_d = comparator_in;
                    sar_d = '0;
                    sar_d[WIDTH-1] = comparator_in;
                end
            end
            ECS_CONV: begin
                if (step) begin
                    cnt_d = cnt_q + 5'd1;
                    ser_d = comparator_in;
                    sar_d[WIDTH-1-int'(cnt_q)] = comparator_in;
                    if (cnt_q == 5'(`ECS_PARALLEL_STEPS - 1)) begin
                        // sixteenth pulse resolves the lsb and holds the word
                        data_d = {sar_q[WIDTH-1:1], comparator_in};
                        st_d = ECS_SHIFT;
                    end
                end
            end
            ECS_SHIFT: begin
                if (step) begin
                    // seventeenth pulse only closes the serial stream and the frame
                    cnt_d = cnt_q + 5'd1;
                    ser_d = 1'b0;
                    status_d = 1'b0;
                    st_d = ECS_IDLE;
                    ext_mode_d = 1'b0;
                end
            end
            default: begin
                st_d = ECS_IDLE;
                status_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= ECS_IDLE;
            cnt_q <= 5'd0;
            sar_q <= '0;
            data_q <= '0;
            status_q <= 1'b0;
            ser_q <= 1'b0;
            step_q <= 1'b0;
            ext_mode_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sar_q <= sar_d;
            data_q <= data_d;
            status_q <= status_d;
            ser_q <= ser_d;
            step_q <= step;
            ext_mode_q <= ext_mode_d;
        end
    end

    assign status_out = status_q;
    assign data_out = data_q;
    assign serial_out = ser_q;
    assign step_out = step_q;
    assign pulse_err_out = err_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence first_pulse_s;
        (st_q == ECS_IDLE) && ext_step;
    endsequence

    status_rise_a: assert property (@(posedge clk_in) disable iff (rst_in)
        first_pulse_s |=> status_q)
        else $error("status did not rise after first pulse");

    status_fall_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (st_q == ECS_SHIFT) && step && (cnt_q == 5'd16) |=> !status_q)
        else $error("status did not fall after seventeenth pulse");

    status_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (st_q == ECS_CONV) |-> status_q)
        else $error("status low during conversion");

    int_inhibit_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (st_q != ECS_IDLE) && int_tick && !ext_step |-> !step)
        else $error("internal step while externally paced");

    parallel_done_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (st_q == ECS_CONV) && step && (cnt_q == 5'd15) |=> (st_q == ECS_SHIFT))
        else $error("conversion not complete after sixteen pulses");

    data_latch_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (st_q == ECS_CONV) && step && (cnt_q == 5'd15) |=> (data_q[0] == $past(comparator_in)))
        else $error("parallel result not latched at sixteenth pulse");

    data_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (st_q == ECS_IDLE) |=> $stable(data_q))
        else $error("parallel result changed while idle");

    serial_done_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(status_q) |-> (st_q == ECS_IDLE) && !ser_q)
        else $error("serial not finished at status fall");

    pulse_check_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ext_step && (low_cnt_q < 8'(PMIN)) |=> pulse_err_out)
        else $error("short trigger pulse not flagged");

endmodule // ecs_sequencer
`default_nettype wire

// ==== ecs_pacer.sv ====
// Purpose: model of the controller that paces conversions
// Assumes: driven just after clk_in rising edges
// Notes: comparator level holds over each pulse, then flips
`timescale 1ns/1ns
`default_nettype none
module ecs_pacer (
    // clock
    input wire logic clk_in,
    // trigger and decision
    output logic trig_n_out,
    output logic comp_out
);
    initial begin
        trig_n_out = 1'b1;
        comp_out = 1'b0;
    end

    // one low pulse of w cycles; pulse period stays slower than the internal clock
    task automatic send(input int w, input logic b);
        @(posedge clk_in);
        comp_out <= b;
        trig_n_out <= 1'b0;
        repeat (w) @(posedge clk_in);
        trig_n_out <= 1'b1;
        repeat (2) @(posedge clk_in);
        // decision no longer valid once the step is taken
        comp_out <= ~b;
        // idle high long enough for the internal divider to tick between pulses
        repeat (10) @(posedge clk_in);
    endtask
endmodule // ecs_pacer
`default_nettype wire

// ==== ecs_sequencer_test.sv ====
// Purpose: self-checking bench for the paced sequencer
// Assumes: 125 MHz clock, widths 13..87 cycles accepted
// Notes: each pulse waits for its outputs before the next
`timescale 1ns/1ns
`default_nettype none
module ecs_sequencer_test;
    import ecs_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic trig_n, comp, status_out, serial_out, step_out, pulse_err_out;
    logic [15:0] data_out;
    logic [15:0] steps = 16'h0;
    logic [15:0] errs = 16'h0;
    int error_cnt = 0;
    int checked = 0;

    always #4 clk_in = ~clk_in;

    ecs_pacer i_ctrl (.clk_in(clk_in), .trig_n_out(trig_n), .comp_out(comp));
    ecs_sequencer i_dut (.clk_in(clk_in), .rst_in(rst_in), .start_conv_n_in(trig_n),
        .comparator_in(comp), .status_out(status_out), .data_out(data_out),
        .serial_out(serial_out), .step_out(step_out), .pulse_err_out(pulse_err_out));

    // --------------------------------
    // monitor and compare
    // --------------------------------
    always @(posedge clk_in) begin
        if (step_out === 1'b1) steps <= steps + 16'h1;
        if (pulse_err_out === 1'b1) errs <= errs + 16'h1;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // 17 pulses of width w, decisions MSB first from pat
    task automatic run_conv(input int w, input logic [15:0] pat, input logic [15:0] exp_err);
        logic [15:0] steps0;
        logic [15:0] errs0;
        steps0 = steps;
        errs0 = errs;
        for (int k = 1; k <= 17; k++) begin
            i_ctrl.send(w, (k < 17) ? pat[16-k] : 1'b0);
            #1;
            if (k == 1) chk({15'h0, status_out}, 16'h1);
            if (k < 17) chk({15'h0, serial_out}, {15'h0, pat[16-k]});
            if (k == 16) chk({15'h0, status_out}, 16'h1);
            if (k == 16) chk(data_out, pat);
        end
        chk({15'h0, status_out}, 16'h0);
        chk({15'h0, serial_out}, 16'h0);
        chk(data_out, pat);
        chk(steps - steps0, 16'd17);
        chk(errs - errs0, exp_err);
        $display("test done width %0d", w);
    endtask

    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_shortest_legal();
        run_conv(13, 16'ha5c3, 16'h0);
    endtask

    task automatic t_longest_legal();
        run_conv(87, 16'h5a3c, 16'h0);
    endtask

    task automatic t_too_short();
        run_conv(12, 16'hffff, 16'd17);
    endtask

    task automatic t_too_long();
        run_conv(88, 16'h0001, 16'd17);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        #1;
        chk({12'h0, status_out, serial_out, step_out, pulse_err_out}, 16'h0);
        chk(data_out, 16'h0);
        t_shortest_legal();
        t_longest_legal();
        t_too_short();
        t_too_long();
        wrap_up();
    end
endmodule // ecs_sequencer_test
`default_nettype wire
